/* src/vls_top.sv */
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
module vls_top (
    input  wire logic        sys_clk_i,                 // System clock, 250 MHz.
    input  wire logic        rst_i,                     // Synchronous reset, active high.
    input  wire logic [7:0]  addr_i,                    // Register byte address.
    input  wire logic [7:0]  wdata_i,                   // Write data.
    input  wire logic        wr_i,                      // Write strobe, one cycle.
    input  wire logic        rd_i,                      // Read strobe, one cycle.
    input  wire logic        one_way_lock_config_i,     // One-way lock setting.
    input  wire logic        seq_abort_i,               // Interrupt or halt in progress.
    output logic [7:0]       rdata_o,                   // Read data, cycle after strobe.
    output logic             vector_base_locked_o,      // Lock bit.
    output logic             shadow_context_switch_o,   // Context switch bit.
    output logic [23:0]      vector_base_o              // Vector base address.
);

    ////////////////////////////////////////////////////////////////////////////
    // Address decode.
    wire logic sel_lock  = (addr_i == vls_pkg::OFS_VECTOR_TABLE_LOCK);
    wire logic sel_shad  = (addr_i == vls_pkg::OFS_SHADOW_CONTEXT_SELECT);
    wire logic sel_key   = (addr_i == vls_pkg::OFS_UNLOCK_KEY);
    wire logic sel_vbl   = (addr_i == vls_pkg::OFS_VECTOR_BASE_L);
    wire logic sel_vbh   = (addr_i == vls_pkg::OFS_VECTOR_BASE_H);
    wire logic sel_vbu   = (addr_i == vls_pkg::OFS_VECTOR_BASE_U);
    wire logic sel_win0  = (addr_i == vls_pkg::OFS_SHADOW_WIN0);
    wire logic sel_win1  = (addr_i == vls_pkg::OFS_SHADOW_WIN1);

    ////////////////////////////////////////////////////////////////////////////
    // Unlock key sequence tracker.
    logic armed;

    vls_unlock u_unlock (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .wr_i      (wr_i),
        .rd_i      (rd_i),
        .key_sel_i (sel_key),
        .wdata_i   (wdata_i),
        .abort_i   (seq_abort_i),
        .armed_o   (armed)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Lock bit: only the write right after the key sequence may change it.
    logic lock_r;
    logic lock_nxt;
    wire logic lock_new    = wdata_i[vls_pkg::BIT_LOCKED];
    wire logic lock_wr_ok  = wr_i & sel_lock & armed & ~seq_abort_i;
    wire logic clear_block = one_way_lock_config_i & lock_r & ~lock_new;

    // Next value keeps the bit unless an armed write is allowed through.
    always_comb begin
        lock_nxt = lock_r;
        if (lock_wr_ok && !clear_block) begin
            lock_nxt = lock_new;
        end
    end

    // Lock register.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            lock_r <= vls_pkg::RST_LOCKED;
        end else begin
            lock_r <= lock_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shadow context switch bit, an ordinary read/write bit.
    logic shad_r;
    wire logic shad_we = wr_i & sel_shad;

    // Context select register.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            shad_r <= vls_pkg::RST_SHADOW_LO;
        end else if (shad_we) begin
            shad_r <= wdata_i[vls_pkg::BIT_SHADOW_LO];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Vector base registers, guarded by the lock bit.
    logic [7:0] vb_r [3];
    wire logic  vb_open = ~lock_r;
    wire logic [2:0] vb_sel = {sel_vbu, sel_vbh, sel_vbl};

    // One write-gated byte register per vector base byte.
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_vb
            always_ff @(posedge sys_clk_i) begin
                if (rst_i) begin
                    vb_r[gi] <= vls_pkg::RST_VECTOR_BASE[gi*8 +: 8];
                end else if (wr_i && vb_sel[gi] && vb_open) begin
                    vb_r[gi] <= wdata_i;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Shadow copies: one bank per context, window steered by the switch bit.
    logic [7:0] shd_main_r [vls_pkg::SHD_N];
    logic [7:0] shd_low_r  [vls_pkg::SHD_N];
    wire logic [1:0] win_sel  = {sel_win1, sel_win0};
    wire logic       to_low   = shad_r;
    wire logic       to_main  = ~shad_r;

    // Window writes land in the bank chosen by the context switch bit.
    genvar si;
    generate
        for (si = 0; si < vls_pkg::SHD_N; si++) begin : g_shd
            always_ff @(posedge sys_clk_i) begin
                if (rst_i) begin
                    shd_main_r[si] <= vls_pkg::RST_SHADOW_BYTE;
                    shd_low_r[si]  <= vls_pkg::RST_SHADOW_BYTE;
                end else if (wr_i && win_sel[si]) begin
                    if (to_main) begin
                        shd_main_r[si] <= wdata_i;
                    end
                    if (to_low) begin
                        shd_low_r[si] <= wdata_i;
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Read data selection; unmapped offsets and the key register read zero.
    wire logic [7:0] rd_lock = {7'h00, lock_r};
    wire logic [7:0] rd_shad = {7'h00, shad_r};
    wire logic [7:0] rd_win0 = to_low ? shd_low_r[0] : shd_main_r[0];
    wire logic [7:0] rd_win1 = to_low ? shd_low_r[1] : shd_main_r[1];
    wire logic [7:0] rd_mux  = sel_lock ? rd_lock
                             : sel_shad ? rd_shad
                             : sel_vbl  ? vb_r[0]
                             : sel_vbh  ? vb_r[1]
                             : sel_vbu  ? vb_r[2]
                             : sel_win0 ? rd_win0
                             : sel_win1 ? rd_win1
                             : vls_pkg::RD_ZERO;

    // Read data stands only in the cycle after the read strobe.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rdata_o <= vls_pkg::RD_ZERO;
        end else if (rd_i) begin
            rdata_o <= rd_mux;
        end else begin
            rdata_o <= vls_pkg::RD_ZERO;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered copies of the control state for the rest of the core.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            vector_base_locked_o    <= vls_pkg::RST_LOCKED;
            shadow_context_switch_o <= vls_pkg::RST_SHADOW_LO;
            vector_base_o           <= vls_pkg::RST_VECTOR_BASE;
        end else begin
            vector_base_locked_o    <= lock_nxt;
            shadow_context_switch_o <= shad_we ? wdata_i[vls_pkg::BIT_SHADOW_LO] : shad_r;
            vector_base_o           <= {vb_r[2], vb_r[1], vb_r[0]};
        end
    end

endmodule : vls_top

/* src/vls_pkg.sv */
package vls_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Bus widths and the shadow window count.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int VB_W   = 24;
    localparam int SHD_N  = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets.
    localparam logic [7:0] OFS_VECTOR_TABLE_LOCK     = 8'h00;
    localparam logic [7:0] OFS_SHADOW_CONTEXT_SELECT = 8'h01;
    localparam logic [7:0] OFS_UNLOCK_KEY            = 8'h02;
    localparam logic [7:0] OFS_VECTOR_BASE_L         = 8'h04;
    localparam logic [7:0] OFS_VECTOR_BASE_H         = 8'h05;
    localparam logic [7:0] OFS_VECTOR_BASE_U         = 8'h06;
    localparam logic [7:0] OFS_SHADOW_WIN0           = 8'h08;
    localparam logic [7:0] OFS_SHADOW_WIN1           = 8'h09;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions and key values.
    localparam int         BIT_LOCKED     = 0;
    localparam int         BIT_SHADOW_LO  = 0;
    localparam logic [7:0] KEY_FIRST      = 8'h55;
    localparam logic [7:0] KEY_SECOND     = 8'hAA;

    ////////////////////////////////////////////////////////////////////////////
    // Values after reset.
    localparam logic        RST_LOCKED      = 1'b0;
    localparam logic        RST_SHADOW_LO   = 1'b0;
    localparam logic [23:0] RST_VECTOR_BASE = 24'h00_0008;
    localparam logic [7:0]  RST_SHADOW_BYTE = 8'h00;
    localparam logic [7:0]  RD_ZERO         = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Unlock sequence states.
    typedef enum logic [1:0] {
        VLS_KEY_IDLE  = 2'b00,
        VLS_KEY_GOT1  = 2'b01,
        VLS_KEY_ARMED = 2'b10
    } vls_key_state_t;

endpackage : vls_pkg

/* src/vls_unlock.sv */
`timescale 1ns/100ps
module vls_unlock (
    input  wire logic       sys_clk_i,     // System clock.
    input  wire logic       rst_i,         // Synchronous reset, active high.
    input  wire logic       wr_i,          // Bus write strobe.
    input  wire logic       rd_i,          // Bus read strobe.
    input  wire logic       key_sel_i,     // Write addresses the key register.
    input  wire logic [7:0] wdata_i,       // Bus write data.
    input  wire logic       abort_i,       // Interrupt or halt voids the sequence.
    output logic            armed_o        // Key sequence just completed.
);

    ////////////////////////////////////////////////////////////////////////////
    // Next-state decode: any access that is not the expected key step voids it.
    vls_pkg::vls_key_state_t state_r;
    vls_pkg::vls_key_state_t state_nxt;
    wire logic access    = wr_i | rd_i;
    wire logic first_ok  = wr_i & key_sel_i & (wdata_i == vls_pkg::KEY_FIRST);
    wire logic second_ok = wr_i & key_sel_i & (wdata_i == vls_pkg::KEY_SECOND);

    // Sequence walks idle, first key, armed; an abort or stray access resets it.
    always_comb begin
        state_nxt = state_r;
        if (abort_i) begin
            state_nxt = vls_pkg::VLS_KEY_IDLE;
        end else if (access) begin
            case (state_r)
                vls_pkg::VLS_KEY_GOT1: begin
                    state_nxt = second_ok ? vls_pkg::VLS_KEY_ARMED
                              : (first_ok ? vls_pkg::VLS_KEY_GOT1 : vls_pkg::VLS_KEY_IDLE);
                end
                default: begin
                    state_nxt = first_ok ? vls_pkg::VLS_KEY_GOT1 : vls_pkg::VLS_KEY_IDLE;
                end
            endcase
        end
    end

    // State register.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_r <= vls_pkg::VLS_KEY_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign armed_o = (state_r == vls_pkg::VLS_KEY_ARMED);

endmodule : vls_unlock

/* verification/vls_top_props.sv */
`timescale 1ns/100ps
module vls_top_props (
    input wire logic        sys_clk_i,               // Clock.
    input wire logic        rst_i,                   // Reset.
    input wire logic [7:0]  addr_i,                  // Address.
    input wire logic [7:0]  wdata_i,                 // Write data.
    input wire logic        wr_i,                    // Write strobe.
    input wire logic        rd_i,                    // Read strobe.
    input wire logic        one_way_lock_config_i,   // One-way setting.
    input wire logic        seq_abort_i,             // Sequence abort.
    input wire logic [7:0]  rdata_o,                 // Read data.
    input wire logic        vector_base_locked_o,    // Lock bit.
    input wire logic        shadow_context_switch_o, // Context bit.
    input wire logic [23:0] vector_base_o            // Vector base.
);
    // All checks share the system clock and pause during reset.
    default clocking @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);

    ////////////////////////////////////////////////////////////////////////////
    // Read data shows only after a read, and the two bits read with zeros above.
    rd_idle_zero_a: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data not zero outside a read");
    lock_read_a: assert property (rd_i && addr_i == 8'h00 |=>
        rdata_o == {7'h00, $past(vector_base_locked_o)}) else $error("lock read wrong");
    ctx_read_a: assert property (rd_i && addr_i == 8'h01 |=>
        rdata_o == {7'h00, $past(shadow_context_switch_o)}) else $error("context read wrong");
    // The lock bit moves only on an unaborted write to its own address.
    lock_change_a: assert property ($changed(vector_base_locked_o) && !$past(rst_i) |->
        $past(wr_i && addr_i == 8'h00 && !seq_abort_i)) else $error("lock moved without write");
    lock_set_a: assert property ($rose(vector_base_locked_o) |-> $past(wdata_i[0]))
        else $error("lock set by a zero");
    one_way_a: assert property (vector_base_locked_o && one_way_lock_config_i && !rst_i |=>
        vector_base_locked_o) else $error("one-way lock cleared");
    base_frozen_a: assert property (vector_base_locked_o && !rst_i |=>
        $stable(vector_base_o)) else $error("vector base changed while locked");
    ctx_change_a: assert property ($changed(shadow_context_switch_o) && !$past(rst_i) |->
        $past(wr_i && addr_i == 8'h01)) else $error("context bit moved without write");
    reset_vals_a: assert property ($fell(rst_i) |-> !vector_base_locked_o &&
        !shadow_context_switch_o && vector_base_o == 24'h00_0008) else $error("reset values wrong");
endmodule : vls_top_props

bind vls_top vls_top_props u_props (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .one_way_lock_config_i(one_way_lock_config_i),
    .seq_abort_i(seq_abort_i), .rdata_o(rdata_o), .vector_base_locked_o(vector_base_locked_o),
    .shadow_context_switch_o(shadow_context_switch_o), .vector_base_o(vector_base_o));

/* verification/tb_vector_lock_shadow_select.sv */
`timescale 1ns/100ps
module tb_vector_lock_shadow_select;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        one_way = 1'b0;
    logic        abort = 1'b0;
    logic [7:0]  rdata;
    logic        lock;
    logic        shad;
    logic [23:0] base;
    int          errors = 0;
    int          tests_run = 0;

    // The clock toggles every 2 ns, half its 4 ns period.
    always #2 clk = ~clk;

    vls_top uut (.sys_clk_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .one_way_lock_config_i(one_way), .seq_abort_i(abort), .rdata_o(rdata),
        .vector_base_locked_o(lock), .shadow_context_switch_o(shad), .vector_base_o(base));

    ////////////////////////////////////////////////////////////////////////////
    // Compare, bus cycles and the closing report.
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk({16'h0000, rdata}, {16'h0000, exp});
    endtask : rd_reg
    // Back-to-back key writes then the lock write, optionally aborted at the end.
    task automatic unlock_wr(input logic [7:0] d, input logic ab);
        @(posedge clk);
        addr  <= 8'h02;
        wdata <= vls_pkg::KEY_FIRST;
        wr    <= 1'b1;
        @(posedge clk);
        wdata <= vls_pkg::KEY_SECOND;
        @(posedge clk);
        addr  <= 8'h00;
        wdata <= d;
        abort <= ab;
        @(posedge clk);
        wr    <= 1'b0;
        abort <= 1'b0;
    endtask : unlock_wr
    task automatic test_done;
        $display("comparisons %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios.
    task automatic t_reset;
        rd_reg(8'h00, 8'h00);
        rd_reg(8'h01, 8'h00);
        chk(base, vls_pkg::RST_VECTOR_BASE);
    endtask : t_reset
    task automatic t_shadow;
        wr_reg(8'h08, 8'hA5);
        wr_reg(8'h01, 8'hFF);
        rd_reg(8'h01, 8'h01);
        chk({23'h00_0000, shad}, 24'h00_0001);
        rd_reg(8'h08, 8'h00);
        wr_reg(8'h08, 8'h5A);
        wr_reg(8'h01, 8'h00);
        rd_reg(8'h08, 8'hA5);
        wr_reg(8'h01, 8'h01);
        rd_reg(8'h08, 8'h5A);
        wr_reg(8'h09, 8'h3C);
        rd_reg(8'h09, 8'h3C);
        wr_reg(8'h01, 8'h00);
        rd_reg(8'h09, 8'h00);
        wr_reg(8'h01, 8'h01);
    endtask : t_shadow
    task automatic t_nokey;
        wr_reg(8'h00, 8'h01);
        rd_reg(8'h00, 8'h00);
        wr_reg(8'h02, vls_pkg::KEY_FIRST);
        wr_reg(8'h02, vls_pkg::KEY_SECOND);
        rd_reg(8'h02, 8'h00);
        wr_reg(8'h00, 8'h01);
        rd_reg(8'h00, 8'h00);
        unlock_wr(8'h01, 1'b1);
        rd_reg(8'h00, 8'h00);
    endtask : t_nokey
    task automatic t_lock;
        wr_reg(8'h04, 8'h34);
        rd_reg(8'h04, 8'h34);
        unlock_wr(8'hFF, 1'b0);
        rd_reg(8'h00, 8'h01);
        chk({23'h00_0000, lock}, 24'h00_0001);
        wr_reg(8'h04, 8'h77);
        rd_reg(8'h04, 8'h34);
        wr_reg(8'h06, 8'h77);
        rd_reg(8'h06, 8'h00);
        chk(base, 24'h00_0034);
    endtask : t_lock
    task automatic t_oneway;
        @(posedge clk);
        one_way <= 1'b1;
        unlock_wr(8'h00, 1'b0);
        rd_reg(8'h00, 8'h01);
        @(posedge clk);
        one_way <= 1'b0;
        unlock_wr(8'h00, 1'b0);
        rd_reg(8'h00, 8'h00);
        wr_reg(8'h04, 8'h77);
        rd_reg(8'h04, 8'h77);
        wr_reg(8'h05, 8'h12);
        rd_reg(8'h05, 8'h12);
        @(posedge clk);
        one_way <= 1'b1;
        unlock_wr(8'h01, 1'b0);
        @(posedge clk);
        rst <= 1'b1;
        chk({23'h00_0000, lock}, 24'h00_0001);
        @(posedge clk);
        rst <= 1'b0;
        rd_reg(8'h00, 8'h00);
        chk(base, vls_pkg::RST_VECTOR_BASE);
        chk({22'h00_0000, lock, shad}, 24'h00_0000);
    endtask : t_oneway

    // Hold reset for 20 cycles, then run every scenario.
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_shadow();
        t_nokey();
        t_lock();
        t_oneway();
        test_done();
    end
endmodule : tb_vector_lock_shadow_select
